// File: mfw_cpu_model.sv
// Processor core model: interrupt source seen by the flash block
module mfw_cpu_model (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_prot_run,
   output logic      o_irq_req
);
   logic [3:0] tick;
   // ====
   // Free running source; muted when running protected code
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) tick <= '0;
      else tick <= tick + 4'h1;
   end
   assign o_irq_req = tick[3] & ~i_prot_run;
endmodule : mfw_cpu_model

// File: mfw_flash_ctrl.sv
// Flash write unlock, stall sequencer and boot address select
//
// What this block does
// - Each processor byte write stalls the processor 740 clock cycles.
// - Page erase stalls the processor up to 360,000 clock cycles.
// - Interrupt service is held off while the stall lasts.
// - Writes and erases into the protected region are rejected.
// - Writing 0xAA to the command register starts a 7-bit countdown from 127.
// - Writing 0x55 before expiry reloads the countdown from 127.
// - Write-enable is settable only during the second countdown.
// - Write-enable stays until cleared; clearing needs no unlock.
// - With write-enable set, command value 0-31 erases that page.
// - Each write programs one byte at the given address, no increment.
// - Operations are self-timed and the processor stops until done.
// - Start-protected high boots at unprotected page count shifted left 9.
// - Start-protected low boots at address 0.
// - Interrupt vectors always resolve into the first flash page.
// - Odd count of ones in the top 16 bytes sets start-protected.
// - Data area disabled forces start-protected low.
// - Write-enable is status bit 5.
// - Not-ready flag is status bit 4, low when ready.
// - Command field is bits 4:0; below 32 means erase page.
// - Protect config bit 7 is data area enable; 6:0 unprotected pages.
module mfw_flash_ctrl #(
   parameter int ERASE_STALL = mfw_pkg::ERASE_CYCLES
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_cmd_wr,
   input  wire logic [7:0]   i_cmd_data,
   input  wire logic         i_stat_wr,
   input  wire logic [7:0]   i_stat_data,
   input  wire logic         i_byte_wr,
   input  wire logic [13:0]  i_byte_addr,
   input  wire logic [7:0]   i_byte_data,
   input  wire logic [7:0]   i_prot_cfg,
   input  wire logic         i_startup_valid,
   input  wire logic [127:0] i_top_bytes,
   input  wire logic         i_irq_req,
   output logic [7:0]        o_flash_status_reg,
   output logic [7:0]        o_flash_command_reg,
   output logic              o_cpu_stall,
   output logic              o_irq_take,
   output logic [13:0]       o_boot_addr,
   output logic [13:0]       o_vector_base,
   output logic              o_prog_strobe,
   output logic              o_erase_strobe,
   output logic [13:0]       o_prog_addr,
   output logic [7:0]        o_prog_data,
   output logic [4:0]        o_erase_page_field,
   output logic              o_access_reject
);
   import mfw_pkg::*;

   // ===========================================================
   // Region decode
   mfw_unlock_e state;
   logic [6:0]  down_cnt;
   logic        wen;
   logic        busy;
   logic [18:0] stall_cnt;
   logic        start_protected_flag;
   logic [7:0]  prot_cfg;

   wire         data_area_enable       = prot_cfg[PCFG_DATA_AREA_ENABLE_BIT];
   wire [6:0]   unprotected_page_count = prot_cfg[6:0];
   wire [4:0]   byte_page              = i_byte_addr[13:9];
   wire [4:0]   erase_page             = i_cmd_data[4:0];
   wire [5:0]   data_first_page        = data_area_enable ? 6'd30 : 6'd32;

   // Data pages are the top two when the data area is enabled; the rest above the unprotected count is protected
   function automatic logic page_open(input logic [4:0] pg);
      page_open = ({1'b0, pg} < {1'b0, unprotected_page_count[4:0]}) ||
                  (unprotected_page_count[6:5] != 2'b00) ||
                  ({1'b0, pg} >= data_first_page);
   endfunction : page_open

   wire         is_page_cmd  = i_cmd_wr && (i_cmd_data < CMD_PAGE_LIMIT);
   wire         erase_ok     = is_page_cmd && wen && !busy && page_open(erase_page);
   wire         write_ok     = i_byte_wr && wen && !busy && page_open(byte_page);
   wire         reject       = (is_page_cmd && wen && !page_open(erase_page)) ||
                               (i_byte_wr && wen && !page_open(byte_page));
   wire         in_window2   = (state == MFW_ARM2);
   wire         wen_req      = i_stat_data[STAT_WEN_BIT];
   wire         next_wen     = (i_stat_wr && !wen_req) ? 1'b0 :
                               (i_stat_wr && wen_req && in_window2) ? 1'b1 : wen;
   wire         parity_odd   = ^i_top_bytes;

   // ===========================================================
   // Unlock sequencer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state    <= MFW_IDLE;
         down_cnt <= 7'h_00;
      end else if (i_cmd_wr && i_cmd_data == CMD_UNLOCK_1) begin
         state    <= MFW_ARM1;
         down_cnt <= UNLOCK_RELOAD;
      end else if (i_cmd_wr && i_cmd_data == CMD_UNLOCK_2 && state == MFW_ARM1) begin
         state    <= MFW_ARM2;
         down_cnt <= UNLOCK_RELOAD;
      end else begin
         case (state)
            MFW_ARM1,
            MFW_ARM2: begin
               // Any other command write breaks the sequence
               if (down_cnt == 7'h_00 || i_cmd_wr) begin
                  state <= MFW_IDLE;
               end else begin
                  down_cnt <= down_cnt - 7'h_01;
               end
            end
            default: state <= MFW_IDLE;
         endcase
      end
   end

   // ===========================================================
   // Write enable and command register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wen <= 1'b0;
      end else begin
         wen <= next_wen;
      end
   end

   // Upper bits read as zero; only the page field is kept
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_flash_command_reg <= 8'h_00;
      end else if (i_cmd_wr) begin
         o_flash_command_reg <= {3'b000, i_cmd_data[4:0]};
      end
   end

   // ===========================================================
   // Self-timed stall; one counter serves both operations
   // Loads are two short of the figure: the accept cycle and the
   // clear cycle both show as stall, so the processor sees the exact count
   wire         stall_now  = busy || write_ok || erase_ok;
   wire         cnt_done   = (stall_cnt == 19'h_0_0000);
   wire [18:0]  write_load = WRITE_STALL - 19'h_0_0002;
   wire [18:0]  erase_load = 19'(ERASE_STALL - 2);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         busy <= 1'b0;
      end else if (write_ok || erase_ok) begin
         busy <= 1'b1;
      end else if (busy && cnt_done) begin
         busy <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stall_cnt <= 19'h_0_0000;
      end else if (write_ok) begin
         stall_cnt <= write_load;
      end else if (erase_ok) begin
         stall_cnt <= erase_load;
      end else if (busy && !cnt_done) begin
         stall_cnt <= stall_cnt - 19'h_0_0001;
      end
   end

   // ===========================================================
   // Strobes toward the flash array
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prog_strobe  <= 1'b0;
         o_erase_strobe <= 1'b0;
      end else begin
         o_prog_strobe  <= write_ok;
         o_erase_strobe <= erase_ok;
      end
   end

   // Address is taken as written; no increment between bytes
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prog_addr <= 14'h_0000;
         o_prog_data <= 8'h_00;
      end else if (write_ok) begin
         o_prog_addr <= i_byte_addr;
         o_prog_data <= i_byte_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_erase_page_field <= 5'h_00;
      end else if (erase_ok) begin
         o_erase_page_field <= erase_page;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_access_reject <= 1'b0;
      end else begin
         o_access_reject <= reject;
      end
   end

   // ===========================================================
   // Start-up capture
   // Captured after reset release since straps may not be read under reset
   wire         stp_next  = parity_odd && i_prot_cfg[PCFG_DATA_AREA_ENABLE_BIT];
   wire [13:0]  boot_next = stp_next ? 14'({i_prot_cfg[6:0], 9'h_000}) :
                                       14'h_0000;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prot_cfg <= 8'h_00;
      end else if (i_startup_valid) begin
         prot_cfg <= i_prot_cfg;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         start_protected_flag <= 1'b0;
      end else if (i_startup_valid) begin
         start_protected_flag <= stp_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_boot_addr <= 14'h_0000;
      end else if (i_startup_valid) begin
         o_boot_addr <= boot_next;
      end
   end

   // ===========================================================
   // Status and processor-side outputs
   // Not-ready mirrors the stall, so polling code and stalled code agree
   wire [7:0]   status_next = {1'b0, start_protected_flag, next_wen,
                               stall_now, 4'h_0};

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_flash_status_reg <= 8'h_00;
      end else begin
         o_flash_status_reg <= status_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cpu_stall <= 1'b0;
      end else begin
         o_cpu_stall <= stall_now;
      end
   end

   // Interrupts are masked while the stall lasts; a request is not stored, only gated
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_take <= 1'b0;
      end else begin
         o_irq_take <= i_irq_req && !stall_now;
      end
   end

   // One vector set, always in the first page
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_vector_base <= 14'h_0000;
      end else begin
         o_vector_base <= 14'h_0000;
      end
   end

endmodule : mfw_flash_ctrl

// File: mfw_flash_ctrl_monitor.sv
// Checker: port properties of the flash control block
module mfw_flash_ctrl_monitor #(
   parameter int ERASE_STALL = 50
) (
   input wire logic         i_clk, i_rst, i_cmd_wr, i_stat_wr, i_startup_valid,
   input wire logic [7:0]   i_cmd_data, i_stat_data, i_byte_data, i_prot_cfg,
   input wire logic [13:0]  i_byte_addr,
   input wire logic [127:0] i_top_bytes,
   input wire logic [7:0]   o_flash_status_reg, o_prog_data,
   input wire logic         o_cpu_stall, o_irq_take, o_prog_strobe, o_erase_strobe,
   input wire logic [13:0]  o_boot_addr, o_prog_addr,
   input wire logic [4:0]   o_erase_page_field,
   input wire logic         o_access_reject
);
   import mfw_pkg::*;
   logic [18:0] run;
   logic        wr_op;
   // ====
   // Stall length, and which kind of operation caused it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         run   <= '0;
         wr_op <= 1'b0;
      end else begin
         run   <= o_cpu_stall ? run + 19'h1 : '0;
         wr_op <= o_prog_strobe | (wr_op & ~o_erase_strobe);
      end
   end
   // ====
   // Properties
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_unlock;
      i_cmd_wr && i_cmd_data == CMD_UNLOCK_1 ##1 i_cmd_wr && i_cmd_data == CMD_UNLOCK_2
         ##1 i_stat_wr && i_stat_data[STAT_WEN_BIT];
   endsequence
   a_write_stall_len: assert property ($fell(o_cpu_stall) && wr_op |-> run == 19'(WRITE_CYCLES))
      else $error("write stall length wrong");
   a_erase_stall_len: assert property ($fell(o_cpu_stall) && !wr_op |-> run == 19'(ERASE_STALL))
      else $error("erase stall length wrong");
   a_irq_held: assert property (o_cpu_stall |-> !o_irq_take)
      else $error("interrupt taken in stall");
   a_unlock_opens: assert property (s_unlock |=> o_flash_status_reg[STAT_WEN_BIT])
      else $error("unlock did not open");
   a_wen_cause: assert property ($rose(o_flash_status_reg[STAT_WEN_BIT]) |-> $past(i_stat_wr))
      else $error("write enable rose uncaused");
   a_wen_clear: assert property (i_stat_wr && !i_stat_data[STAT_WEN_BIT] |=>
      !o_flash_status_reg[STAT_WEN_BIT]) else $error("write enable not cleared");
   a_erase_page: assert property (i_cmd_wr && i_cmd_data < CMD_PAGE_LIMIT
      && o_flash_status_reg[STAT_WEN_BIT] && !o_cpu_stall |=> o_access_reject
      || o_erase_strobe && o_erase_page_field == $past(i_cmd_data[4:0])) else $error("no erase");
   a_prog_exact: assert property (o_prog_strobe |-> o_prog_addr == $past(i_byte_addr)
      && o_prog_data == $past(i_byte_data)) else $error("program address or data wrong");
   a_start_parity: assert property ($past(i_startup_valid, 2) |->
      o_flash_status_reg[STAT_STP_BIT] ==
      (^$past(i_top_bytes, 2) & $past(i_prot_cfg[PCFG_DATA_AREA_ENABLE_BIT], 2)))
      else $error("start flag wrong");
   a_boot_addr: assert property ($past(i_startup_valid) |-> o_boot_addr ==
      ((^$past(i_top_bytes) & $past(i_prot_cfg[PCFG_DATA_AREA_ENABLE_BIT])) ?
      14'({$past(i_prot_cfg[6:0]), 9'h0}) : 14'h0))
      else $error("boot address wrong");
endmodule : mfw_flash_ctrl_monitor

// File: mfw_flash_ctrl_tb.sv
// Testbench: processor accesses to the flash control block
module mfw_flash_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mfw_pkg::*;
   localparam int ES = 50;
   logic i_clk = 0, i_rst = 1, i_cmd_wr = 0, i_stat_wr = 0, i_byte_wr = 0, i_startup_valid = 0;
   logic i_irq_req, o_cpu_stall, o_irq_take, o_prog_strobe, o_erase_strobe, o_access_reject;
   logic [7:0]   i_cmd_data = '0, i_stat_data = '0, i_byte_data = '0, i_prot_cfg = '0;
   logic [7:0]   o_flash_status_reg, o_flash_command_reg, o_prog_data;
   logic [13:0]  i_byte_addr = '0, o_boot_addr, o_vector_base, o_prog_addr;
   logic [127:0] i_top_bytes = '0;
   logic [4:0]   o_erase_page_field;
   int n_errors = 0, tests_run = 0;
   always #12.5 i_clk = ~i_clk;
   mfw_flash_ctrl #(.ERASE_STALL(ES)) u_dut (.*);
   mfw_cpu_model u_cpu (.i_clk(i_clk), .i_rst(i_rst),
      .i_prot_run(o_flash_status_reg[STAT_STP_BIT]), .o_irq_req(i_irq_req));
   // ====
   // Helpers
   task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // Strobe stays up until the caller's next put or idle, so no double drive
   task automatic put(input int k, input logic [7:0] d, input logic [13:0] a = '0);
      {i_startup_valid, i_byte_wr, i_stat_wr, i_cmd_wr} = 4'(1 << k);
      {i_cmd_data, i_stat_data, i_byte_data, i_byte_addr} = {d, d, d, a};
      @(negedge i_clk);
   endtask : put
   task automatic idle(input int n);
      {i_startup_valid, i_byte_wr, i_stat_wr, i_cmd_wr} = '0;
      repeat (n) @(negedge i_clk);
   endtask : idle
   task automatic boot(input logic [7:0] c, input logic [127:0] t, input logic s, logic [13:0] b);
      {i_prot_cfg, i_top_bytes} = {c, t};
      put(3, 8'h0);
      idle(1);
      chk(o_flash_status_reg[STAT_STP_BIT], s);
      chk(o_boot_addr, b);
   endtask : boot
   task automatic unlock(input int gap, input logic exp);
      put(1, 8'h00);
      chk(o_flash_status_reg[STAT_WEN_BIT], 0);
      put(0, CMD_UNLOCK_1);
      if (gap > 0) idle(gap);
      put(0, CMD_UNLOCK_2);
      chk(o_flash_command_reg, 8'h15);
      if (gap > 0) idle(gap);
      put(1, 8'h20);
      idle(1);
      chk(o_flash_status_reg[STAT_WEN_BIT], exp);
   endtask : unlock
   // Polls the not-ready flag, as code in data RAM would
   task automatic op(input int k, logic [7:0] d, logic [13:0] a, logic stb, rej, input int len);
      int n = 0;
      put(k, d, a);
      chk(o_prog_strobe | o_erase_strobe, stb);
      chk(o_access_reject, rej);
      if (stb) chk(k == 2 ? o_prog_addr : 14'(o_erase_page_field), k == 2 ? a : 14'(d));
      idle(0);
      while (o_flash_status_reg[STAT_NRDY_BIT] === 1'b1 && n < 1000) begin
         n++;
         @(negedge i_clk);
      end
      chk(n, len);
      @(negedge i_clk);
   endtask : op
   // ====
   // Main sequence
   initial begin
      repeat (3) @(negedge i_clk);
      i_rst = 0;
      boot(8'h88, 128'h1, 1, 14'h1000);
      boot(8'h08, 128'h1, 0, 14'h0);
      boot(8'h88, 128'h3, 0, 14'h0);
      unlock(0, 1);
      unlock(130, 0);
      unlock(100, 1);
      op(2, 8'h5A, 14'h0123, 1, 0, WRITE_CYCLES);
      op(2, 8'hA5, 14'h1000, 0, 1, 0);
      op(0, 8'd30, 14'h0, 1, 0, ES);
      op(0, 8'd3, 14'h0, 1, 0, ES);
      op(0, 8'd9, 14'h0, 0, 1, 0);
      put(1, 8'h00);
      idle(1);
      op(2, 8'h11, 14'h0124, 0, 0, 0);
      chk(o_vector_base, 14'h0);
      print_verdict;
   end
   initial begin
      #500000;
      n_errors++;
      print_verdict;
   end
endmodule : mfw_flash_ctrl_tb
bind mfw_flash_ctrl mfw_flash_ctrl_monitor #(.ERASE_STALL(ERASE_STALL)) u_mon (.*);

// File: mfw_pkg.sv
// Package: constants for the flash write unlock and boot select block
package mfw_pkg;

   // ===========================================================
   // Register field positions
   localparam int STAT_WEN_BIT   = 5;
   localparam int STAT_NRDY_BIT  = 4;
   localparam int STAT_STP_BIT   = 6;
   localparam int PCFG_DATA_AREA_ENABLE_BIT  = 7;

   // ===========================================================
   // Command values and limits
   localparam logic [7:0] CMD_UNLOCK_1   = 8'h_AA;
   localparam logic [7:0] CMD_UNLOCK_2   = 8'h_55;
   localparam logic [7:0] CMD_PAGE_LIMIT = 8'h_20;
   localparam logic [6:0] UNLOCK_RELOAD  = 7'h_7F;
   localparam int         PAGE_SHIFT     = 9;
   localparam int         TOP_BYTES      = 16;

   // ===========================================================
   // Timing counts in system clock cycles
   localparam int         WRITE_CYCLES   = 740;
   localparam int         ERASE_CYCLES   = 360000;
   localparam logic [18:0] WRITE_STALL   = 19'(WRITE_CYCLES);

   // ===========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      MFW_IDLE  = 2'b00,
      MFW_ARM1  = 2'b01,
      MFW_ARM2  = 2'b10
   } mfw_unlock_e;

endpackage : mfw_pkg
